// *** hw/sbc_defines.vh ***
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// ****************************************************************
// Timing
// ****************************************************************
`define SBC_CLK_MHZ 20
`define SBC_T_WAKE_US 30
`define SBC_SPI_HALF 4

// ****************************************************************
// Flash instructions
// ****************************************************************
`define SBC_OP_WAKE 8'hab
`define SBC_OP_FREAD 8'h0b
`define SBC_FLASH_ADDR 24'h000000
`define SBC_CMD_LAST 3'h4

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define SBC_ADR_CTRL 8'h00
`define SBC_ADR_LEN 8'h04
`define SBC_ADR_STATUS 8'h08
`define SBC_ADR_IRQ_STAT 8'h0c
`define SBC_ADR_IRQ_MASK 8'h10

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SBC_CTRL_ENC 0
`define SBC_CTRL_AUTH 1
`define SBC_CTRL_COMP 2
`define SBC_CTRL_RST 3'h0
`define SBC_LEN_RST 24'h000400
`define SBC_ST_USER 0
`define SBC_ST_HALT_SEC 1
`define SBC_ST_HALT_FMT 2
`define SBC_ST_BUSY 3
`define SBC_ST_JLOCK 4
`define SBC_ST_STATE 8
`define SBC_IRQ_USER 0
`define SBC_IRQ_FAIL 1
`define SBC_IRQ_JREF 2
`define SBC_IRQ_RST 3'h0

// ****************************************************************
// JTAG instruction codes
// ****************************************************************
`define SBC_IR_IDCODE 4'h1
`define SBC_IR_BYPASS 4'hf

`endif

// *** hw/sbc_spi_byte.v ***
`timescale 1ns/1ps
`include "sbc_defines.vh"

module sbc_spi_byte
#(
  parameter HALF = `SBC_SPI_HALF
)
(
  input wire core_clk,
  input wire srst,
  input wire start,
  input wire [7:0] tx,
  input wire miso_f,
  output reg busy,
  output reg done,
  output reg [7:0] rx,
  output reg sclk,
  output reg mosi
);

  reg [7:0] div_r;
  reg [2:0] bit_r;
  reg [7:0] sh_r;

  // ****************************************************************
  // Mode 0 shifter
  // ****************************************************************
  // Input is sampled at the end of the high half, which leaves the
  // three-stage pin filter time to settle after the flash shifts out.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      rx <= 8'h00;
      sclk <= 1'b0;
      mosi <= 1'b0;
      div_r <= 8'h00;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (!busy)
      begin
        if (start)
        begin
          busy <= 1'b1;
          sh_r <= tx;
          mosi <= tx[7];
          bit_r <= 3'h0;
          div_r <= 8'h00;
        end
      end
      else if (div_r == HALF - 1)
      begin
        div_r <= 8'h00;
        if (!sclk)
        begin
          sclk <= 1'b1;
        end
        else
        begin
          sclk <= 1'b0;
          sh_r <= {sh_r[6:0], miso_f};
          if (bit_r == 3'h7)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            rx <= {sh_r[6:0], miso_f};
          end
          else
          begin
            bit_r <= bit_r + 3'h1;
            mosi <= sh_r[6];
          end
        end
      end
      else
      begin
        div_r <= div_r + 8'h01;
      end
    end
  end

endmodule // sbc_spi_byte

// *** hw/sbc_cfg_ctrl.v ***
// Operation
// - With encryption on, decrypt the stream with the 256-bit fuse key.
// - With authentication on, check the stream signature and public key.
// - A good signature lets loading finish and then enters user mode.
// - A bad signature aborts loading and never releases user mode.
// - Encryption and authentication are enabled independently.
// - With the JTAG fuse blown, only identification and bypass remain.
// - The JTAG block is permanent once the fuse is set.
// - JTAG bitstreams need a valid signature when authentication is on.
// - Loading starts on the rising edge of the configuration reset.
// - Send a flash wake instruction, then wait at least 30 us.
// - Then issue a fast read from flash address zero.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "sbc_defines.vh"

module sbc_cfg_ctrl
(
  input wire core_clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire irq,
  input wire config_reset_n,
  output wire flash_sclk,
  output reg flash_cs_n,
  output wire flash_mosi,
  input wire flash_miso,
  input wire [255:0] fuse_aes_key,
  input wire fuse_jtag_block,
  input wire [3:0] jtag_ir,
  input wire jtag_ir_upd,
  output reg jtag_instr_ok,
  input wire jtag_cfg_start,
  input wire jtag_cfg_valid,
  input wire [7:0] jtag_cfg_data,
  output reg sec_start,
  output reg sec_valid,
  output reg [7:0] sec_data,
  output reg sec_last,
  output reg sec_aes_en,
  output reg sec_auth_en,
  output reg [255:0] sec_key,
  input wire sec_done,
  input wire sec_sig_ok,
  input wire sec_hash_ok,
  output reg user_mode,
  output reg cfg_halted
);

  localparam S_IDLE = 4'h0;
  localparam S_WAKE = 4'h1;
  localparam S_WAITW = 4'h2;
  localparam S_CMD = 4'h3;
  localparam S_DATA = 4'h4;
  localparam S_JTAG = 4'h5;
  localparam S_VERIFY = 4'h6;
  localparam S_USER = 4'h7;
  localparam S_HALT = 4'h8;
  localparam [9:0] WAKE_CYC = `SBC_T_WAKE_US * `SBC_CLK_MHZ;
  localparam [23:0] FLASH_ADDR = `SBC_FLASH_ADDR;

  reg [3:0] state_r;
  reg [2:0] ctrl_r;
  reg [23:0] len_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg halt_fmt_r;
  reg lock_r;
  reg [9:0] tmr_r;
  reg [2:0] idx_r;
  reg [23:0] cnt_r;
  reg spi_start_r;
  reg [7:0] spi_tx_r;
  reg crn_s1_r;
  reg crn_s2_r;
  reg crn_s3_r;
  reg crn_lvl_r;
  reg miso_s1_r;
  reg miso_s2_r;
  reg miso_s3_r;
  reg miso_f_r;
  reg ev_user;
  reg ev_fail;
  reg ev_jref;
  wire spi_busy;
  wire spi_done;
  wire [7:0] spi_rx;
  wire crn_rise;
  wire secure;
  wire locked;
  wire ir_free;
  wire jtag_go;
  wire acc;
  wire [2:0] irq_stat_nxt;
  wire [31:0] status;

  // ****************************************************************
  // Pin filters
  // ****************************************************************
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      crn_s1_r <= 1'b1;
      crn_s2_r <= 1'b1;
      crn_s3_r <= 1'b1;
      crn_lvl_r <= 1'b1;
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
      miso_s3_r <= 1'b0;
      miso_f_r <= 1'b0;
    end
    else
    begin
      crn_s1_r <= config_reset_n;
      crn_s2_r <= crn_s1_r;
      crn_s3_r <= crn_s2_r;
      if (crn_s2_r == crn_s3_r)
      begin
        crn_lvl_r <= crn_s2_r;
      end
      miso_s1_r <= flash_miso;
      miso_s2_r <= miso_s1_r;
      miso_s3_r <= miso_s2_r;
      if (miso_s2_r == miso_s3_r)
      begin
        miso_f_r <= miso_s2_r;
      end
    end
  end

  // Reset levels start high, so only a real low pulse starts a load.
  assign crn_rise = (crn_s2_r == crn_s3_r) && crn_s2_r && !crn_lvl_r;

  // ****************************************************************
  // Flash byte engine
  // ****************************************************************
  sbc_spi_byte #(.HALF(`SBC_SPI_HALF)) u_spi
  (
    .core_clk(core_clk),
    .srst(srst),
    .start(spi_start_r),
    .tx(spi_tx_r),
    .miso_f(miso_f_r),
    .busy(spi_busy),
    .done(spi_done),
    .rx(spi_rx),
    .sclk(flash_sclk),
    .mosi(flash_mosi)
  );

  // ****************************************************************
  // JTAG gate
  // ****************************************************************
  // The fuse is also read directly, so the block holds even in the
  // cycles after a reset before the sticky copy has caught up.
  assign locked = lock_r | fuse_jtag_block;
  assign ir_free = (jtag_ir == `SBC_IR_IDCODE) ||
                   (jtag_ir == `SBC_IR_BYPASS);
  assign jtag_go = jtag_cfg_start && !locked && ((state_r == S_IDLE) ||
                   (state_r == S_USER) || (state_r == S_HALT));

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      lock_r <= 1'b0;
      jtag_instr_ok <= 1'b0;
      ev_jref <= 1'b0;
    end
    else
    begin
      lock_r <= locked;
      ev_jref <= 1'b0;
      if (jtag_ir_upd)
      begin
        jtag_instr_ok <= !locked || ir_free;
        ev_jref <= locked && !ir_free;
      end
      else if (locked && !ir_free)
      begin
        jtag_instr_ok <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Load sequencer
  // ****************************************************************
  assign secure = ctrl_r[`SBC_CTRL_ENC] | ctrl_r[`SBC_CTRL_AUTH];

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      state_r <= S_IDLE;
      flash_cs_n <= 1'b1;
      tmr_r <= 10'h000;
      idx_r <= 3'h0;
      cnt_r <= 24'h000000;
      spi_start_r <= 1'b0;
      spi_tx_r <= 8'h00;
      sec_start <= 1'b0;
      sec_valid <= 1'b0;
      sec_data <= 8'h00;
      sec_last <= 1'b0;
      sec_aes_en <= 1'b0;
      sec_auth_en <= 1'b0;
      sec_key <= 256'h0;
      user_mode <= 1'b0;
      cfg_halted <= 1'b0;
      halt_fmt_r <= 1'b0;
      ev_user <= 1'b0;
      ev_fail <= 1'b0;
    end
    else
    begin
      spi_start_r <= 1'b0;
      sec_start <= 1'b0;
      sec_valid <= 1'b0;
      sec_last <= 1'b0;
      ev_user <= 1'b0;
      ev_fail <= 1'b0;
      sec_key <= sec_aes_en ? fuse_aes_key : 256'h0;
      // The rise itself falls through, so idle can start the load.
      if (!crn_lvl_r && !crn_rise)
      begin
        state_r <= S_IDLE;
        flash_cs_n <= 1'b1;
        user_mode <= 1'b0;
        cfg_halted <= 1'b0;
        halt_fmt_r <= 1'b0;
      end
      else if (jtag_go)
      begin
        state_r <= S_JTAG;
        cnt_r <= 24'h000000;
        user_mode <= 1'b0;
        cfg_halted <= 1'b0;
        halt_fmt_r <= 1'b0;
        sec_aes_en <= ctrl_r[`SBC_CTRL_ENC];
        sec_auth_en <= ctrl_r[`SBC_CTRL_AUTH];
        sec_start <= 1'b1;
      end
      else
      begin
        case (state_r)
          S_IDLE:
          begin
            if (crn_rise)
            begin
              sec_aes_en <= ctrl_r[`SBC_CTRL_ENC];
              sec_auth_en <= ctrl_r[`SBC_CTRL_AUTH];
              if (ctrl_r[`SBC_CTRL_COMP] && secure)
              begin
                state_r <= S_HALT;
                cfg_halted <= 1'b1;
                halt_fmt_r <= 1'b1;
                ev_fail <= 1'b1;
              end
              else
              begin
                state_r <= S_WAKE;
                flash_cs_n <= 1'b0;
                spi_tx_r <= `SBC_OP_WAKE;
                spi_start_r <= 1'b1;
              end
            end
          end
          S_WAKE:
          begin
            if (spi_done)
            begin
              flash_cs_n <= 1'b1;
              tmr_r <= 10'h000;
              state_r <= S_WAITW;
            end
          end
          S_WAITW:
          begin
            tmr_r <= tmr_r + 10'h001;
            if (tmr_r == WAKE_CYC - 10'h001)
            begin
              flash_cs_n <= 1'b0;
              idx_r <= 3'h0;
              spi_tx_r <= `SBC_OP_FREAD;
              spi_start_r <= 1'b1;
              state_r <= S_CMD;
            end
          end
          S_CMD:
          begin
            if (spi_done)
            begin
              spi_start_r <= 1'b1;
              idx_r <= idx_r + 3'h1;
              if (idx_r == `SBC_CMD_LAST)
              begin
                spi_tx_r <= 8'h00;
                cnt_r <= 24'h000000;
                sec_start <= 1'b1;
                state_r <= S_DATA;
              end
              else if (idx_r == 3'h0)
              begin
                spi_tx_r <= FLASH_ADDR[23:16];
              end
              else if (idx_r == 3'h1)
              begin
                spi_tx_r <= FLASH_ADDR[15:8];
              end
              else if (idx_r == 3'h2)
              begin
                spi_tx_r <= FLASH_ADDR[7:0];
              end
              else
              begin
                spi_tx_r <= 8'h00;
              end
            end
          end
          S_DATA:
          begin
            if (spi_done)
            begin
              sec_data <= spi_rx;
              sec_valid <= 1'b1;
              cnt_r <= cnt_r + 24'h000001;
              if (cnt_r == len_r - 24'h000001)
              begin
                sec_last <= 1'b1;
                flash_cs_n <= 1'b1;
                state_r <= S_VERIFY;
              end
              else
              begin
                spi_start_r <= 1'b1;
              end
            end
          end
          S_JTAG:
          begin
            if (jtag_cfg_valid)
            begin
              sec_data <= jtag_cfg_data;
              sec_valid <= 1'b1;
              cnt_r <= cnt_r + 24'h000001;
              if (cnt_r == len_r - 24'h000001)
              begin
                sec_last <= 1'b1;
                state_r <= S_VERIFY;
              end
            end
          end
          S_VERIFY:
          begin
            if (!sec_aes_en && !sec_auth_en)
            begin
              state_r <= S_USER;
              user_mode <= 1'b1;
              ev_user <= 1'b1;
            end
            else if (sec_done)
            begin
              if ((!sec_auth_en || sec_sig_ok) && sec_hash_ok)
              begin
                state_r <= S_USER;
                user_mode <= 1'b1;
                ev_user <= 1'b1;
              end
              else
              begin
                state_r <= S_HALT;
                cfg_halted <= 1'b1;
                ev_fail <= 1'b1;
              end
            end
          end
          S_USER:
          begin
            state_r <= S_USER;
          end
          S_HALT:
          begin
            state_r <= S_HALT;
          end
          default:
          begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Register slave
  // ****************************************************************
  // A transfer takes effect at the edge where the master sees ack.
  assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign status = {20'h00000, state_r, 3'h0, locked,
                   (state_r != S_IDLE) && !user_mode && !cfg_halted,
                   halt_fmt_r, cfg_halted && !halt_fmt_r, user_mode};
  // A read clears only the bits it returned, so an event that lands
  // between capture and ack is kept; a fresh event wins over the clear.
  assign irq_stat_nxt = (irq_stat_r & ~((acc && !wb_we_i &&
                          wb_adr_i == `SBC_ADR_IRQ_STAT) ?
                         wb_dat_o[2:0] : 3'h0)) |
                        {ev_jref, ev_fail, ev_user};
  assign irq = |(irq_stat_r & irq_mask_r);

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_r <= `SBC_CTRL_RST;
      len_r <= `SBC_LEN_RST;
      irq_stat_r <= `SBC_IRQ_RST;
      irq_mask_r <= `SBC_IRQ_RST;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      irq_stat_r <= irq_stat_nxt;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        if (wb_adr_i == `SBC_ADR_CTRL)
        begin
          wb_dat_o <= {29'h0, ctrl_r};
        end
        else if (wb_adr_i == `SBC_ADR_LEN)
        begin
          wb_dat_o <= {8'h00, len_r};
        end
        else if (wb_adr_i == `SBC_ADR_STATUS)
        begin
          wb_dat_o <= status;
        end
        else if (wb_adr_i == `SBC_ADR_IRQ_STAT)
        begin
          wb_dat_o <= {29'h0, irq_stat_r};
        end
        else if (wb_adr_i == `SBC_ADR_IRQ_MASK)
        begin
          wb_dat_o <= {29'h0, irq_mask_r};
        end
        else
        begin
          wb_dat_o <= 32'h00000000;
        end
      end
      if (acc && wb_we_i)
      begin
        if (wb_adr_i == `SBC_ADR_CTRL && wb_sel_i[0])
        begin
          ctrl_r <= wb_dat_i[2:0];
        end
        else if (wb_adr_i == `SBC_ADR_LEN)
        begin
          if (wb_sel_i[0])
          begin
            len_r[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1])
          begin
            len_r[15:8] <= wb_dat_i[15:8];
          end
          if (wb_sel_i[2])
          begin
            len_r[23:16] <= wb_dat_i[23:16];
          end
        end
        else if (wb_adr_i == `SBC_ADR_IRQ_MASK && wb_sel_i[0])
        begin
          irq_mask_r <= wb_dat_i[2:0];
        end
      end
    end
  end

endmodule // sbc_cfg_ctrl

// *** testbench/sbc_cfg_checker_properties.sv ***
`timescale 1ns/1ps
`include "sbc_defines.vh"
module sbc_cfg_checker
(
  input wire core_clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire config_reset_n,
  input wire flash_cs_n,
  input wire [255:0] fuse_aes_key,
  input wire fuse_jtag_block,
  input wire [3:0] jtag_ir,
  input wire jtag_ir_upd,
  input wire jtag_instr_ok,
  input wire jtag_cfg_start,
  input wire sec_start,
  input wire sec_aes_en,
  input wire sec_auth_en,
  input wire [255:0] sec_key,
  input wire sec_done,
  input wire sec_sig_ok,
  input wire sec_hash_ok,
  input wire user_mode,
  input wire cfg_halted
);
  reg [9:0] high_r;
  // Saturates, so the wake selection right after the pin rise is never
  // mistaken for a short gap.
  always @(posedge core_clk)
    if (srst || !config_reset_n)
      high_r <= 10'h3ff;
    else if (!flash_cs_n)
      high_r <= 10'h000;
    else if (high_r != 10'h3ff)
      high_r <= high_r + 10'h001;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o)
    else $error("request not answered");
  a_wake_gap: assert property ($fell(flash_cs_n) |->
    high_r >= 10'h258)
    else $error("flash wake gap short");
  a_verdict_pass: assert property (sec_done && sec_hash_ok &&
    (sec_sig_ok || !sec_auth_en) |=> user_mode && !cfg_halted)
    else $error("good image not released");
  a_verdict_fail: assert property (sec_done && sec_auth_en &&
    !sec_sig_ok |=> cfg_halted && !user_mode)
    else $error("bad signature released");
  a_hash_fail: assert property (sec_done && !sec_hash_ok |=>
    cfg_halted && !user_mode)
    else $error("digest mismatch released");
  a_key_gate: assert property ($stable(sec_aes_en) |->
    sec_key == (sec_aes_en ? fuse_aes_key : 256'h0))
    else $error("engine key wrong");
  a_jtag_open: assert property (jtag_ir_upd && !fuse_jtag_block
    |=> jtag_instr_ok)
    else $error("open instruction refused");
  a_jtag_shut: assert property (jtag_ir_upd && fuse_jtag_block &&
    jtag_ir != `SBC_IR_IDCODE && jtag_ir != `SBC_IR_BYPASS |=> !jtag_instr_ok)
    else $error("blocked instruction allowed");
  a_start_ignored: assert property (fuse_jtag_block && jtag_cfg_start
    |=> !sec_start)
    else $error("blocked load started");
  a_pin_idle: assert property ($fell(config_reset_n) |-> ##[1:8]
    (flash_cs_n && !user_mode && !cfg_halted))
    else $error("pin low did not idle");
endmodule // sbc_cfg_checker
bind sbc_cfg_ctrl sbc_cfg_checker u_chk (.core_clk(core_clk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .config_reset_n(config_reset_n), .flash_cs_n(flash_cs_n),
  .fuse_aes_key(fuse_aes_key), .fuse_jtag_block(fuse_jtag_block),
  .jtag_ir(jtag_ir), .jtag_ir_upd(jtag_ir_upd), .jtag_instr_ok(jtag_instr_ok),
  .jtag_cfg_start(jtag_cfg_start), .sec_start(sec_start),
  .sec_aes_en(sec_aes_en), .sec_auth_en(sec_auth_en), .sec_key(sec_key),
  .sec_done(sec_done), .sec_sig_ok(sec_sig_ok), .sec_hash_ok(sec_hash_ok),
  .user_mode(user_mode), .cfg_halted(cfg_halted));

// *** testbench/sbc_flash_model.sv ***
`timescale 1ns/1ps
module sbc_flash_model
(
  input wire flash_sclk,
  input wire flash_cs_n,
  input wire flash_mosi,
  output reg flash_miso,
  output integer err_cnt
);
  reg [7:0] sh_r;
  reg [7:0] cmd_r = 8'h00;
  reg awake_r = 1'b0;
  integer bits = 0;
  initial
  begin
    flash_miso = 1'b1;
    err_cnt = 0;
  end
  function automatic bit dbit(input integer d);
    reg [7:0] b;
    b = 8'h5a ^ 8'(d / 8);
    dbit = b[7 - d % 8];
  endfunction
  always @(negedge flash_cs_n)
    bits = 0;
  // A released line flips, so a stale sample cannot pass for data.
  always @(posedge flash_cs_n)
    flash_miso = ~flash_miso;
  always @(posedge flash_sclk)
  begin
    sh_r = {sh_r[6:0], flash_mosi};
    bits = bits + 1;
    if (bits == 8)
    begin
      cmd_r = sh_r;
      if (sh_r == 8'hab)
        awake_r = 1'b1;
      else if (sh_r != 8'h0b || !awake_r)
        err_cnt = err_cnt + 1;
    end
    else if (bits <= 32 && bits % 8 == 0 && sh_r != 8'h00)
      err_cnt = err_cnt + 1;
  end
  always @(negedge flash_sclk)
    if (!flash_cs_n && cmd_r == 8'h0b && bits >= 40)
      flash_miso = dbit(bits - 40);
endmodule // sbc_flash_model

// *** testbench/test_secure_bitstream_config_ctrl.sv ***
`timescale 1ns/1ps
`include "sbc_defines.vh"
module test_secure_bitstream_config_ctrl;
  localparam [255:0] KEY = {8{32'h3c5a96e1}};
  reg core_clk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0, config_reset_n = 1'b1, fuse_jtag_block = 1'b0;
  reg [7:0] wb_adr_i = 8'h00, jtag_cfg_data = 8'h00;
  reg [3:0] wb_sel_i = 4'hf, jtag_ir = 4'h0;
  reg [31:0] wb_dat_i = 32'h0, rd;
  reg jtag_ir_upd = 1'b0, jtag_cfg_start = 1'b0, jtag_cfg_valid = 1'b0;
  reg sec_done = 1'b0, sec_sig_ok = 1'b0, sec_hash_ok = 1'b0, cs_seen = 1'b0;
  reg [2:0] mask = 3'h2;
  wire [31:0] wb_dat_o;
  wire [7:0] sec_data;
  wire [255:0] sec_key;
  wire wb_ack_o, irq, flash_sclk, flash_cs_n, flash_mosi, flash_miso;
  wire jtag_instr_ok, sec_start, sec_valid, sec_last, sec_aes_en;
  wire sec_auth_en, user_mode, cfg_halted;
  integer fail_count = 0, comparisons = 0, cycles = 0, got = 0, starts = 0;
  integer flash_errs;
  sbc_cfg_ctrl dut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .config_reset_n(config_reset_n),
    .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n),
    .flash_mosi(flash_mosi), .flash_miso(flash_miso), .fuse_aes_key(KEY),
    .fuse_jtag_block(fuse_jtag_block), .jtag_ir(jtag_ir),
    .jtag_ir_upd(jtag_ir_upd), .jtag_instr_ok(jtag_instr_ok),
    .jtag_cfg_start(jtag_cfg_start), .jtag_cfg_valid(jtag_cfg_valid),
    .jtag_cfg_data(jtag_cfg_data), .sec_start(sec_start),
    .sec_valid(sec_valid), .sec_data(sec_data), .sec_last(sec_last),
    .sec_aes_en(sec_aes_en), .sec_auth_en(sec_auth_en), .sec_key(sec_key),
    .sec_done(sec_done), .sec_sig_ok(sec_sig_ok),
    .sec_hash_ok(sec_hash_ok), .user_mode(user_mode),
    .cfg_halted(cfg_halted));
  sbc_flash_model flash (.flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n),
    .flash_mosi(flash_mosi), .flash_miso(flash_miso), .err_cnt(flash_errs));
  always #25 core_clk = ~core_clk;
  always @(negedge flash_cs_n)
    cs_seen = 1'b1;
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (sec_start === 1'b1)
      starts = starts + 1;
    if (sec_valid === 1'b1)
    begin
      check(sec_data, 8'h5a ^ got[7:0]);
      got = got + 1;
    end
    if (cycles == 30000)
    begin
      fail_count = fail_count + 1;
      results;
    end
  end
  task results;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input [255:0] seen, input [255:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wb(input we, input [7:0] adr, input [31:0] dat);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge core_clk);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task jir(input [3:0] code, input exp);
    @(posedge core_clk);
    jtag_ir <= code;
    jtag_ir_upd <= 1'b1;
    @(posedge core_clk);
    jtag_ir_upd <= 1'b0;
    @(posedge core_clk);
    check(jtag_instr_ok, exp);
  endtask
  task pin_pulse;
    @(posedge core_clk);
    config_reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    config_reset_n <= 1'b1;
  endtask
  // One load through flash or JTAG, then a verdict from the engine stand-in when encryption or authentication is on.
  task load(input [5:0] c);
    integer n;
    reg ok;
    ok = c[0] && (c[1] || !c[3]) || c[3:2] == 2'b00;
    wb(1'b1, `SBC_ADR_CTRL, {29'h0, c[4:2]});
    got = 0;
    if (c[5])
    begin
      @(posedge core_clk);
      jtag_cfg_start <= 1'b1;
      @(posedge core_clk);
      jtag_cfg_start <= 1'b0;
      for (n = 0; n < 4; n = n + 1)
      begin
        @(posedge core_clk);
        jtag_cfg_valid <= 1'b1;
        jtag_cfg_data <= 8'h5a ^ n[7:0];
        @(posedge core_clk);
        jtag_cfg_valid <= 1'b0;
      end
    end
    else
      pin_pulse;
    n = 0;
    while (sec_last !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      n = n + 1;
    end
    @(posedge core_clk);
    check(got, 4);
    check({sec_aes_en, sec_auth_en}, {c[2], c[3]});
    check(sec_key, c[2] ? KEY : 256'h0);
    if (c[3:2] != 2'b00)
    begin
      sec_done <= 1'b1;
      sec_sig_ok <= c[1];
      sec_hash_ok <= c[0];
      @(posedge core_clk);
      sec_done <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
    check({user_mode, cfg_halted}, {ok, !ok});
    wb(1'b0, `SBC_ADR_STATUS, 32'h0);
    check(rd[2:0], {1'b0, !ok, ok});
    check(irq, |(mask & {1'b0, !ok, ok}));
    wb(1'b0, `SBC_ADR_IRQ_STAT, 32'h0);
    check(rd[2:0], {1'b0, !ok, ok});
    @(posedge core_clk);
    check(irq, 1'b0);
    $display("load %b done", c);
  endtask
  task t_regs;
    integer i;
    reg [7:0] adr [0:5];
    adr = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
    for (i = 0; i < 6; i = i + 1)
    begin
      wb(1'b0, adr[i], 32'h0);
      check(rd, i == 1 ? `SBC_LEN_RST : 32'h0);
    end
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b1, `SBC_ADR_LEN, 32'h4);
    wb(1'b1, `SBC_ADR_IRQ_MASK, {29'h0, mask});
    wb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, `SBC_ADR_LEN, 32'h0);
    check(rd, 32'h4);
    $display("register test done");
  endtask
  // Bits: JTAG route, compress, authenticate, encrypt, signature, digest.
  task t_verdicts;
    integer i;
    reg [5:0] tab [0:6];
    tab = '{6'b100000, 6'b100101, 6'b101001, 6'b101010, 6'b101111,
      6'b001111, 6'b001001};
    for (i = 0; i < 7; i = i + 1)
      load(tab[i]);
  endtask
  task t_comp;
    cs_seen = 1'b0;
    wb(1'b1, `SBC_ADR_CTRL, 32'h5);
    pin_pulse;
    repeat (20) @(posedge core_clk);
    check({cs_seen, cfg_halted, user_mode}, 3'b010);
    wb(1'b0, `SBC_ADR_STATUS, 32'h0);
    check(rd[2:0], 3'h4);
    $display("compression test done");
  endtask
  task t_lock;
    integer i, s;
    jir(4'h2, 1'b1);
    fuse_jtag_block <= 1'b1;
    jir(`SBC_IR_IDCODE, 1'b1);
    jir(`SBC_IR_BYPASS, 1'b1);
    jir(4'h2, 1'b0);
    wb(1'b0, `SBC_ADR_IRQ_STAT, 32'h0);
    check(rd[2], 1'b1);
    s = starts;
    @(posedge core_clk);
    jtag_cfg_start <= 1'b1;
    @(posedge core_clk);
    jtag_cfg_start <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(starts, s);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    jir(4'h2, 1'b0);
    $display("lock test done");
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    t_regs;
    t_verdicts;
    t_comp;
    t_lock;
    check(flash_errs, 0);
    results;
  end
endmodule // test_secure_bitstream_config_ctrl
